// ==== logic/sdlc_rx_pkg.sv ====
// Shared constants and types of the bit-oriented receive and loop block.
package sdlc_rx_pkg;

  // ---------------------------------------------------------------------------
  // Character and line patterns
  // ---------------------------------------------------------------------------
  localparam int CHAR_BITS = 8;
  localparam logic [3:0] CHAR_BITS_CNT = 4'h8;
  localparam logic [3:0] DELAY_DEPTH = 4'h8;
  localparam logic [3:0] DRAIN_BITS_LEFT = 4'h6;
  localparam logic [2:0] STUFF_ONES = 3'h5;
  localparam logic [2:0] FLAG_ONES = 3'h6;
  localparam logic [2:0] ONES_MAX = 3'h7;
  localparam logic [1:0] CHAR_INT_EXTRA_BITS = 2'h3;

  // ---------------------------------------------------------------------------
  // Receive interrupt mode field encodings
  // ---------------------------------------------------------------------------
  localparam logic [1:0] RX_INT_DISABLED = 2'h0;
  localparam logic [1:0] RX_INT_FIRST_CHAR = 2'h1;
  localparam logic [1:0] RX_INT_ALL_CHARS = 2'h2;
  localparam logic [1:0] RX_INT_SPECIAL_ONLY = 2'h3;

  // ---------------------------------------------------------------------------
  // Buffer entry layout
  // ---------------------------------------------------------------------------
  localparam int ENTRY_BYTE_LSB = 0;
  localparam int ENTRY_EOF_BIT = 8;
  localparam int ENTRY_FIRST_BIT = 9;
  localparam int ENTRY_SPECIAL_BIT = 10;
  localparam int ENTRY_WIDTH = 11;
  localparam int BUFFER_DEPTH = 2;

  // ---------------------------------------------------------------------------
  // State types
  // ---------------------------------------------------------------------------
  typedef enum logic [0:0] {RX_HUNT, RX_SYNC} rx_state_e;
  typedef enum logic [1:0] {LOOP_OFF, LOOP_GATE, LOOP_RELAY, LOOP_SEND} loop_state_e;

endpackage

// ==== logic/stream_if.sv ====
// Valid and ready carrier between the receiver and its entry buffer.
`timescale 1ns/1ps
interface stream_if #(parameter int WIDTH = 8) ();
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

// ==== logic/entry_buffer.sv ====
// Small first-in first-out buffer of received entries.
`timescale 1ns/1ps
module entry_buffer #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 2
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  stream_if.sink fill,
  stream_if.source drain
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // ---------------------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------------------
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("entry_buffer depth must be a power of two of at least two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Ready is honest: a full buffer refuses the writer, which then stalls.
  assign fill.ready = (count != (AW+1)'(DEPTH));
  assign drain.valid = (count != '0);
  assign drain.data = mem[rd_ptr];
  assign push = fill.valid && fill.ready;
  assign pop = drain.valid && drain.ready;

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr] <= fill.data;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// ==== logic/sdlc_rx_loop.sv ====
// Bit-oriented frame receiver with DMA requests, interrupts and loop relay.
`timescale 1ns/1ps
module sdlc_rx_loop
  import sdlc_rx_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic rx_clk_i,
  input wire logic rx_data_i,
  input wire logic [1:0] rx_interrupt_mode_field_i,
  input wire logic dma_enable_i,
  input wire logic overrun_int_enable_i,
  input wire logic abort_int_enable_i,
  input wire logic int_next_char_cmd_i,
  input wire logic error_reset_cmd_i,
  input wire logic reset_ext_status_cmd_i,
  input wire logic dma_ack_i,
  input wire logic loop_mode_i,
  input wire logic go_active_on_poll_i,
  input wire logic msg_pending_i,
  input wire logic own_tx_bit_i,
  input wire logic own_tx_active_i,
  output logic sync_match_n_o,
  output logic dma_req_o,
  output logic [7:0] rx_byte_o,
  output logic int_o,
  output logic char_avail_int_o,
  output logic special_int_o,
  output logic ext_status_int_o,
  output logic hunt_o,
  output logic break_abort_o,
  output logic end_of_frame_o,
  output logic overrun_o,
  output logic buffer_locked_o,
  output logic on_loop_o,
  output logic loop_sending_o,
  output logic tx_data_o
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers and bit strobe
  // ---------------------------------------------------------------------------
  logic rxc_meta;
  logic rxc_sync;
  logic rxc_prev;
  logic rxd_meta;
  logic rxd_sync;
  logic bit_tick;
  logic line_bit;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rxc_meta <= 1'b0;
      rxc_sync <= 1'b0;
      rxc_prev <= 1'b0;
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
    end else begin
      rxc_meta <= rx_clk_i;
      rxc_sync <= rxc_meta;
      rxc_prev <= rxc_sync;
      rxd_meta <= rx_data_i;
      rxd_sync <= rxd_meta;
    end
  end

  // Data is sampled on the rising edge of the line clock.
  assign bit_tick = rxc_sync && !rxc_prev;
  assign line_bit = rxd_sync;

  // ---------------------------------------------------------------------------
  // Line pattern detection
  // ---------------------------------------------------------------------------
  logic [2:0] ones;
  logic flag_seen;
  logic seventh_one;
  logic data_bit;

  // After five ones a zero is stuffing and a one belongs to a flag or abort.
  assign data_bit = bit_tick && (ones < STUFF_ONES);
  assign flag_seen = bit_tick && (ones == FLAG_ONES) && !line_bit;
  // A zero followed by seven ones is both an abort and the end-of-poll pattern.
  assign seventh_one = bit_tick && (ones == FLAG_ONES) && line_bit;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ones <= ONES_MAX;
    end else if (bit_tick) begin
      if (!line_bit) begin
        ones <= '0;
      end else if (ones != ONES_MAX) begin
        ones <= ones + 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_match_n_o <= 1'b1;
    end else if (bit_tick) begin
      sync_match_n_o <= !flag_seen;
    end
  end

  // ---------------------------------------------------------------------------
  // Hunt and sync state, character assembly
  // ---------------------------------------------------------------------------
  rx_state_e rx_state;
  logic [7:0] delay_line;
  logic [3:0] delay_count;
  logic [7:0] shifter;
  logic [3:0] char_count;
  logic first_pending;
  logic char_done;
  logic [7:0] next_char;
  logic char_is_last;
  logic loop_hunt;

  // Received bits wait in a delay line so that the bits of a flag never
  // reach the character shifter; a flag drains the last two data bits.
  always_comb begin
    char_done = 1'b0;
    char_is_last = 1'b0;
    next_char = {delay_line[7], shifter[7:1]};
    if (rx_state == RX_SYNC && flag_seen && delay_count == DELAY_DEPTH &&
        char_count == DRAIN_BITS_LEFT) begin
      char_done = 1'b1;
      char_is_last = 1'b1;
      next_char = {delay_line[6], delay_line[7], shifter[7:2]};
    end else if (rx_state == RX_SYNC && data_bit && delay_count == DELAY_DEPTH &&
                 char_count == CHAR_BITS_CNT - 4'h1) begin
      char_done = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_state <= RX_HUNT;
      delay_line <= '0;
      delay_count <= '0;
      shifter <= '0;
      char_count <= '0;
      first_pending <= 1'b1;
    end else if (seventh_one || loop_hunt) begin
      rx_state <= RX_HUNT;
      delay_count <= '0;
      char_count <= '0;
    end else if (flag_seen) begin
      // One flag both closes a frame and opens the next.
      rx_state <= RX_SYNC;
      delay_count <= '0;
      char_count <= '0;
      first_pending <= 1'b1;
    end else if (rx_state == RX_SYNC && data_bit) begin
      delay_line <= {delay_line[6:0], line_bit};
      if (delay_count != DELAY_DEPTH) begin
        delay_count <= delay_count + 4'h1;
      end else begin
        shifter <= next_char;
        if (char_done) begin
          char_count <= '0;
          first_pending <= 1'b0;
        end else begin
          char_count <= char_count + 4'h1;
        end
      end
    end
  end

  assign hunt_o = (rx_state == RX_HUNT);

  // ---------------------------------------------------------------------------
  // Staging: three further bit-times before a character is offered
  // ---------------------------------------------------------------------------
  stream_if #(.WIDTH(ENTRY_WIDTH)) fill_s ();
  stream_if #(.WIDTH(ENTRY_WIDTH)) drain_s ();

  logic stage_valid;
  logic [1:0] stage_wait;
  logic [ENTRY_WIDTH-1:0] stage_entry;
  logic stage_lost;
  logic stage_offer;

  assign stage_offer = stage_valid && (stage_wait == CHAR_INT_EXTRA_BITS);
  assign fill_s.valid = stage_offer;
  assign fill_s.data = stage_entry;
  // A stalled entry waits in the stage; only a newer character overwrites it.
  assign stage_lost = char_done && stage_valid && !(stage_offer && fill_s.ready);

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stage_valid <= 1'b0;
      stage_wait <= '0;
      stage_entry <= '0;
    end else begin
      if (char_done) begin
        // Check bytes are staged exactly like payload bytes.
        stage_valid <= 1'b1;
        stage_wait <= '0;
        stage_entry[ENTRY_BYTE_LSB +: CHAR_BITS] <= next_char;
        stage_entry[ENTRY_EOF_BIT] <= char_is_last;
        stage_entry[ENTRY_FIRST_BIT] <= first_pending;
        // The character that overwrites a lost one carries the overrun mark.
        stage_entry[ENTRY_SPECIAL_BIT] <= stage_lost;
      end else if (stage_offer && fill_s.ready) begin
        stage_valid <= 1'b0;
      end else if (stage_valid && bit_tick && !stage_offer) begin
        stage_wait <= stage_wait + 2'h1;
      end
    end
  end

  entry_buffer #(
    .WIDTH(ENTRY_WIDTH),
    .DEPTH(BUFFER_DEPTH)
  ) u_entry_buffer (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .fill(fill_s),
    .drain(drain_s)
  );

  // ---------------------------------------------------------------------------
  // Buffer head: DMA requests, lock and receive interrupts
  // ---------------------------------------------------------------------------
  logic head_valid;
  logic head_eof;
  logic head_first;
  logic head_special;
  logic eof_taken;
  logic next_char_armed;
  logic char_int_cond;
  logic head_read;
  logic head_pop;
  logic [1:0] mode;

  assign mode = rx_interrupt_mode_field_i;
  assign head_valid = drain_s.valid;
  assign head_eof = drain_s.data[ENTRY_EOF_BIT];
  assign head_first = drain_s.data[ENTRY_FIRST_BIT];
  assign head_special = drain_s.data[ENTRY_SPECIAL_BIT];
  assign rx_byte_o = drain_s.data[ENTRY_BYTE_LSB +: CHAR_BITS];

  // Mode 11 and mode 00 never raise character interrupts.
  always_comb begin
    char_int_cond = 1'b0;
    if (head_valid && !buffer_locked_o) begin
      if (mode == RX_INT_ALL_CHARS) begin
        char_int_cond = 1'b1;
      end else if (mode == RX_INT_FIRST_CHAR && head_first && next_char_armed) begin
        char_int_cond = 1'b1;
      end
    end
  end

  assign char_avail_int_o = char_int_cond;
  assign dma_req_o = dma_enable_i && head_valid && !buffer_locked_o &&
                     !char_int_cond && (mode != RX_INT_ALL_CHARS);
  assign head_read = dma_ack_i && head_valid && !buffer_locked_o;
  // The first read of the closing byte only locks; it leaves the byte in place.
  assign head_pop = head_read && !(head_eof && !eof_taken);
  assign drain_s.ready = head_pop;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      eof_taken <= 1'b0;
      buffer_locked_o <= 1'b0;
      end_of_frame_o <= 1'b0;
    end else begin
      if (head_read && head_eof && !eof_taken) begin
        eof_taken <= 1'b1;
        buffer_locked_o <= 1'b1;
        end_of_frame_o <= 1'b1;
      end else begin
        if (head_pop) begin
          eof_taken <= 1'b0;
        end
        if (error_reset_cmd_i) begin
          // No receiver reinitialisation: unlocking alone resumes service.
          buffer_locked_o <= 1'b0;
          end_of_frame_o <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      next_char_armed <= 1'b1;
    end else if (int_next_char_cmd_i) begin
      next_char_armed <= 1'b1;
    end else if (head_pop && head_first && char_int_cond) begin
      next_char_armed <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Special-condition and status interrupts
  // ---------------------------------------------------------------------------
  logic special_event;
  logic ext_event;

  assign special_event = (head_read && head_eof && !eof_taken) ||
                         (head_pop && head_special && overrun_int_enable_i);

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      special_int_o <= 1'b0;
      overrun_o <= 1'b0;
    end else begin
      if (special_event) begin
        special_int_o <= 1'b1;
      end else if (error_reset_cmd_i) begin
        special_int_o <= 1'b0;
      end
      if (stage_lost) begin
        overrun_o <= 1'b1;
      end else if (error_reset_cmd_i) begin
        overrun_o <= 1'b0;
      end
    end
  end

  loop_state_e loop_state;
  logic loop_entry;

  assign loop_entry = (loop_state == LOOP_GATE) && seventh_one;
  assign ext_event = (flag_seen && rx_state == RX_HUNT) ||
                     (seventh_one && rx_state == RX_SYNC) ||
                     (seventh_one && abort_int_enable_i) || loop_entry;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_status_int_o <= 1'b0;
      break_abort_o <= 1'b0;
    end else begin
      if (ext_event) begin
        ext_status_int_o <= 1'b1;
      end else if (reset_ext_status_cmd_i) begin
        ext_status_int_o <= 1'b0;
      end
      if (seventh_one) begin
        break_abort_o <= 1'b1;
      end else if (bit_tick && !line_bit) begin
        break_abort_o <= 1'b0;
      end
    end
  end

  assign int_o = char_avail_int_o || special_int_o || ext_status_int_o;

  // ---------------------------------------------------------------------------
  // Loop relay of a secondary station
  // ---------------------------------------------------------------------------
  logic poll_taken;

  // Only the last one of the pattern is turned into a zero, forming a flag.
  assign poll_taken = (loop_state == LOOP_RELAY) && seventh_one &&
                      go_active_on_poll_i && msg_pending_i;
  assign loop_hunt = loop_entry;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      loop_state <= LOOP_OFF;
      on_loop_o <= 1'b0;
    end else if (!loop_mode_i) begin
      loop_state <= LOOP_OFF;
      on_loop_o <= 1'b0;
    end else begin
      case (loop_state)
        LOOP_OFF: begin
          loop_state <= LOOP_GATE;
        end
        LOOP_GATE: begin
          if (loop_entry) begin
            loop_state <= LOOP_RELAY;
            on_loop_o <= 1'b1;
          end
        end
        LOOP_RELAY: begin
          if (poll_taken) begin
            loop_state <= LOOP_SEND;
          end
        end
        LOOP_SEND: begin
          if (!own_tx_active_i) begin
            loop_state <= LOOP_RELAY;
          end
        end
        default: begin
          loop_state <= LOOP_OFF;
        end
      endcase
    end
  end

  assign loop_sending_o = (loop_state == LOOP_SEND);

  // Pass-through costs two synchroniser stages and the output register rather than a true gate delay.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_data_o <= 1'b1;
    end else begin
      case (loop_state)
        LOOP_GATE: begin
          tx_data_o <= line_bit;
        end
        LOOP_RELAY: begin
          if (bit_tick) begin
            tx_data_o <= poll_taken ? 1'b0 : line_bit;
          end
        end
        LOOP_SEND: begin
          if (bit_tick) begin
            tx_data_o <= own_tx_active_i ? own_tx_bit_i : 1'b1;
          end
        end
        default: begin
          tx_data_o <= 1'b1;
        end
      endcase
    end
  end

endmodule

// ==== bench/serial_line_model.sv ====
// Serial line partner that clocks bits into the receiver, least significant bit first.
`timescale 1ns/1ps
module serial_line_model (
  input wire logic clock_i,
  output logic rx_clk_o,
  output logic rx_data_o
);
  // The clock stands still between frames and the line holds its last bit, so no stale
  // data bit is ever mistaken for traffic.
  initial begin
    rx_clk_o = 1'b0;
    rx_data_o = 1'b1;
  end

  task automatic send_bit(input logic b);
    @(negedge clock_i);
    rx_data_o = b;
    repeat (4) @(negedge clock_i);
    rx_clk_o = 1'b1;
    repeat (4) @(negedge clock_i);
    rx_clk_o = 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) send_bit(b[i]);
  endtask

  task automatic send_ones(input int n);
    repeat (n) send_bit(1'b1);
  endtask

  task automatic send_poll();
    send_bit(1'b0);
    send_ones(7);
  endtask
endmodule

// ==== bench/sdlc_rx_loop_sva.sv ====
// Port-level assertions of the receive and loop block.
`timescale 1ns/1ps
module sdlc_rx_loop_sva
  import sdlc_rx_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [1:0] rx_interrupt_mode_field_i,
  input wire logic dma_enable_i,
  input wire logic int_next_char_cmd_i,
  input wire logic error_reset_cmd_i,
  input wire logic dma_ack_i,
  input wire logic loop_mode_i,
  input wire logic go_active_on_poll_i,
  input wire logic msg_pending_i,
  input wire logic sync_match_n_o,
  input wire logic dma_req_o,
  input wire logic char_avail_int_o,
  input wire logic special_int_o,
  input wire logic ext_status_int_o,
  input wire logic hunt_o,
  input wire logic break_abort_o,
  input wire logic end_of_frame_o,
  input wire logic buffer_locked_o,
  input wire logic on_loop_o,
  input wire logic loop_sending_o,
  input wire logic tx_data_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  hunt_exit_a: assert property ($fell(hunt_o) |-> !sync_match_n_o)
    else $error("hunt left without sync match");
  sync_pulse_a: assert property ($fell(sync_match_n_o) |=>
    !sync_match_n_o [*2] ##[1:40] sync_match_n_o) else $error("sync match width wrong");
  req_hold_a: assert property (dma_req_o && !dma_ack_i && dma_enable_i &&
    !int_next_char_cmd_i |=> dma_req_o || buffer_locked_o) else $error("request dropped");
  lock_quiet_a: assert property (buffer_locked_o |-> !dma_req_o)
    else $error("request while locked");
  lock_flags_a: assert property ($rose(buffer_locked_o) |-> end_of_frame_o && special_int_o)
    else $error("lock without end of frame interrupt");
  unlock_clear_a: assert property (buffer_locked_o && error_reset_cmd_i && !dma_ack_i
    |=> !buffer_locked_o && !end_of_frame_o) else $error("error reset did not unlock");
  special_only_a: assert property (rx_interrupt_mode_field_i == RX_INT_SPECIAL_ONLY
    |-> !char_avail_int_o) else $error("character interrupt in special only mode");
  char_or_req_a: assert property (char_avail_int_o |-> !dma_req_o)
    else $error("character interrupt and request together");
  loop_entry_a: assert property ($rose(on_loop_o) |-> ext_status_int_o && break_abort_o
    && hunt_o) else $error("loop entry flags wrong");
  send_entry_a: assert property ($rose(loop_sending_o) |-> on_loop_o && go_active_on_poll_i
    && msg_pending_i) else $error("sending without poll permission");
  mark_idle_a: assert property (!loop_mode_i [*3] |-> tx_data_o)
    else $error("transmit line not marking");

  cover property ($rose(buffer_locked_o));
  cover property ($rose(on_loop_o));
  cover property ($rose(loop_sending_o));
endmodule

bind sdlc_rx_loop sdlc_rx_loop_sva u_sva (.clock_i, .rstn_i, .rx_interrupt_mode_field_i,
  .dma_enable_i, .int_next_char_cmd_i, .error_reset_cmd_i, .dma_ack_i, .loop_mode_i,
  .go_active_on_poll_i, .msg_pending_i, .sync_match_n_o, .dma_req_o, .char_avail_int_o,
  .special_int_o, .ext_status_int_o, .hunt_o, .break_abort_o, .end_of_frame_o,
  .buffer_locked_o, .on_loop_o, .loop_sending_o, .tx_data_o);

// ==== bench/sdlc_rx_loop_tb.sv ====
// Self-checking bench of the receive and loop block.
`timescale 1ns/1ps
module sdlc_rx_loop_tb;
  import sdlc_rx_pkg::*;
  logic clock_i, rstn_i, rx_clk_i, rx_data_i, dma_enable_i, overrun_int_enable_i;
  logic abort_int_enable_i, int_next_char_cmd_i, error_reset_cmd_i, reset_ext_status_cmd_i;
  logic dma_ack_i, loop_mode_i, go_active_on_poll_i, msg_pending_i, own_tx_bit_i;
  logic own_tx_active_i, sync_match_n_o, dma_req_o, int_o, char_avail_int_o, special_int_o;
  logic ext_status_int_o, hunt_o, break_abort_o, end_of_frame_o, overrun_o, buffer_locked_o;
  logic on_loop_o, loop_sending_o, tx_data_o;
  logic [1:0] rx_interrupt_mode_field_i;
  logic [7:0] rx_byte_o;
  int bad_count, tests_run;

  sdlc_rx_loop u_dut (.clock_i, .rstn_i, .rx_clk_i, .rx_data_i, .rx_interrupt_mode_field_i,
    .dma_enable_i, .overrun_int_enable_i, .abort_int_enable_i, .int_next_char_cmd_i,
    .error_reset_cmd_i, .reset_ext_status_cmd_i, .dma_ack_i, .loop_mode_i,
    .go_active_on_poll_i, .msg_pending_i, .own_tx_bit_i, .own_tx_active_i, .sync_match_n_o,
    .dma_req_o, .rx_byte_o, .int_o, .char_avail_int_o, .special_int_o, .ext_status_int_o,
    .hunt_o, .break_abort_o, .end_of_frame_o, .overrun_o, .buffer_locked_o, .on_loop_o,
    .loop_sending_o, .tx_data_o);
  serial_line_model u_line (.clock_i, .rx_clk_o(rx_clk_i), .rx_data_o(rx_data_i));

  task automatic print_verdict();
    if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk(what, {7'h0, exp}, {7'h0, got});
  endtask

  // Every wait is bounded so a stuck design ends the run instead of hanging it.
  task automatic wait_for(input string what, ref logic sig, input logic val);
    int n;
    n = 0;
    while (sig !== val && n < 3000) begin
      @(negedge clock_i);
      n++;
    end
    if (sig !== val) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen timeout", what, val);
      print_verdict();
    end
  endtask

  task automatic pulse(ref logic sig);
    sig = 1'b1;
    @(negedge clock_i);
    sig = 1'b0;
    @(negedge clock_i);
  endtask

  task automatic take(input logic [7:0] exp, input logic by_dma);
    if (by_dma) wait_for("dma_req_o", dma_req_o, 1'b1);
    else wait_for("char_avail_int_o", char_avail_int_o, 1'b1);
    chk("rx_byte_o", exp, rx_byte_o);
    chk_bit("dma_req_o", by_dma, dma_req_o);
    pulse(dma_ack_i);
  endtask

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  initial begin
    {rstn_i, overrun_int_enable_i, abort_int_enable_i, int_next_char_cmd_i} = '0;
    {error_reset_cmd_i, reset_ext_status_cmd_i, dma_ack_i, loop_mode_i} = '0;
    {go_active_on_poll_i, msg_pending_i, own_tx_bit_i, own_tx_active_i} = '0;
    rx_interrupt_mode_field_i = RX_INT_FIRST_CHAR;
    dma_enable_i = 1'b1;
    bad_count = 0;
    tests_run = 0;
    repeat (6) @(negedge clock_i);
    chk_bit("hunt_o", 1'b1, hunt_o);
    chk_bit("tx_data_o", 1'b1, tx_data_o);
    rstn_i = 1'b1;
    fork
      begin
        u_line.send_byte(8'h7E);
        u_line.send_byte(8'h81);
        u_line.send_byte(8'h42);
        u_line.send_byte(8'h3C);
        u_line.send_byte(8'hA5);
        u_line.send_byte(8'h7E);
        u_line.send_byte(8'h01);
        u_line.send_byte(8'h03);
        u_line.send_byte(8'h7E);
        u_line.send_ones(8);
      end
      begin
        wait_for("sync_match_n_o", sync_match_n_o, 1'b0);
        chk_bit("hunt_o", 1'b0, hunt_o);
        chk_bit("ext_status_int_o", 1'b1, ext_status_int_o);
        pulse(reset_ext_status_cmd_i);
        take(8'h81, 1'b0);
        take(8'h42, 1'b1);
        take(8'h3C, 1'b1);
        take(8'hA5, 1'b1);
        chk_bit("buffer_locked_o", 1'b1, buffer_locked_o);
        chk_bit("special_int_o", 1'b1, special_int_o);
        chk_bit("end_of_frame_o", 1'b1, end_of_frame_o);
        chk_bit("dma_req_o", 1'b0, dma_req_o);
        pulse(int_next_char_cmd_i);
        dma_enable_i = 1'b0;
        pulse(error_reset_cmd_i);
        chk_bit("dma_req_o", 1'b0, dma_req_o);
        dma_enable_i = 1'b1;
        take(8'hA5, 1'b1);
        chk_bit("buffer_locked_o", 1'b0, buffer_locked_o);
        take(8'h01, 1'b0);
        chk_bit("hunt_o", 1'b0, hunt_o);
        take(8'h03, 1'b1);
        chk_bit("end_of_frame_o", 1'b1, end_of_frame_o);
        pulse(error_reset_cmd_i);
        take(8'h03, 1'b1);
      end
    join
    wait_for("hunt_o", hunt_o, 1'b1);
    chk_bit("ext_status_int_o", 1'b1, ext_status_int_o);
    chk_bit("int_o", 1'b1, int_o);
    rx_interrupt_mode_field_i = RX_INT_SPECIAL_ONLY;
    pulse(reset_ext_status_cmd_i);
    loop_mode_i = 1'b1;
    u_line.send_poll();
    wait_for("on_loop_o", on_loop_o, 1'b1);
    chk_bit("ext_status_int_o", 1'b1, ext_status_int_o);
    chk_bit("break_abort_o", 1'b1, break_abort_o);
    abort_int_enable_i = 1'b1;
    pulse(reset_ext_status_cmd_i);
    go_active_on_poll_i = 1'b1;
    msg_pending_i = 1'b1;
    own_tx_active_i = 1'b1;
    u_line.send_poll();
    chk_bit("ext_status_int_o", 1'b1, ext_status_int_o);
    wait_for("loop_sending_o", loop_sending_o, 1'b1);
    chk_bit("tx_data_o", 1'b0, tx_data_o);
    own_tx_bit_i = 1'b1;
    u_line.send_bit(1'b0);
    chk_bit("tx_data_o", 1'b1, tx_data_o);
    own_tx_active_i = 1'b0;
    u_line.send_ones(3);
    wait_for("loop_sending_o", loop_sending_o, 1'b0);
    chk_bit("tx_data_o", 1'b1, tx_data_o);
    u_line.send_bit(1'b0);
    chk_bit("tx_data_o", 1'b0, tx_data_o);
    chk_bit("overrun_o", 1'b0, overrun_o);
    print_verdict();
  end
endmodule
